// ### hdl/sysref_delay_calibration.sv
// Calibration of the sampling clock aperture delay against SYSREF, with its registers.
// Assumes sysref is synchronous to clock and a master that never needs a wait state.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

module sysref_delay_calibration (
  input wire logic clock,
  input wire logic rstn,
  input wire sysref_calib_pkg::regBusReq_t busReq,
  output logic [7:0] readData,
  input wire logic sysref,
  output sysref_calib_pkg::apertureDelay_t apertureDelay,
  output logic calibrating,
  output logic irq
);
  import sysref_calib_pkg::*;

  localparam calState_t STATE_RESET = '{calConfig: CONFIG_RESET[3:0], manualDelay: MANUAL_RESET[16:0],
                                        phase: CAL_IDLE, applied: '0, default: '0};

  calState_t state;
  calState_t next_state;

  logic [9:0] regIndex;
  logic aligned;
  logic writeHit;
  logic startPulse;
  logic [1:0] avgCode;
  logic [1:0] windowCode;
  logic [8:0] avgTarget;
  logic [8:0] windowLen;
  logic [15:0] maxPeriod;
  logic [3:0] avgShift;
  logic edgePulse;
  logic meterArmed;
  logic meterTooLong;
  logic [8:0] highNext;
  logic [16:0] accNext;
  logic [24:0] scaled;
  logic [1:0] events;
  logic [23:0] statusWord;
  logic [23:0] manualWord;
  logic [16:0] chosenDelay;

  // ==========================================================================
  // Decode of the configuration fields
  // ==========================================================================
  assign avgCode = state.calConfig[AVG_LSB +: 2];
  assign windowCode = state.calConfig[WINDOW_LSB +: 2];

  always_comb begin
    case (avgCode)
      2'h0: avgTarget = AVG_COUNT0;
      2'h1: avgTarget = AVG_COUNT1;
      2'h2: avgTarget = AVG_COUNT2;
      2'h3: avgTarget = AVG_COUNT3;
      default: avgTarget = AVG_COUNT0;
    endcase
    case (windowCode)
      2'h0: begin
        windowLen = WINDOW_LEN0;
        maxPeriod = MAX_PERIOD0;
      end
      2'h1: begin
        windowLen = WINDOW_LEN1;
        maxPeriod = MAX_PERIOD1;
      end
      2'h2: begin
        windowLen = WINDOW_LEN2;
        maxPeriod = MAX_PERIOD2;
      end
      2'h3: begin
        windowLen = WINDOW_LEN3;
        maxPeriod = MAX_PERIOD3;
      end
      default: begin
        windowLen = WINDOW_LEN0;
        maxPeriod = MAX_PERIOD0;
      end
    endcase
  end

  // Dividing by the average count is a shift of two bits per code step
  assign avgShift = {1'b0, avgCode, 1'b0} + 4'h2;

  // ==========================================================================
  // SYSREF period watchdog
  // ==========================================================================
  sysref_period_meter meter (
    .clock(clock),
    .rstn(rstn),
    .sysref(sysref),
    .clear(startPulse),
    .limit(maxPeriod),
    .risingEdge(edgePulse),
    .armed(meterArmed),
    .tooLong(meterTooLong)
  );

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  assign regIndex = busReq.addr[ADDR_W-1:2];
  assign aligned = (busReq.addr[1:0] == 2'h0);
  assign writeHit = busReq.writeStrobe & aligned;
  // Only a 0-to-1 change of the enable bit starts a run; rewriting 1 does nothing
  assign startPulse = writeHit & (regIndex == IDX_ENABLE) & busReq.writeData[0] & ~state.calEnable;

  assign statusWord = {6'h00, state.complete & state.calEnable, state.result};
  assign manualWord = {7'h00, state.manualDelay};

  assign highNext = state.highCount + {8'h00, sysref};
  assign accNext = state.acc + {8'h00, highNext};
  assign scaled = {accNext, 8'h00} >> avgShift;

  // Manual value is ignored while calibration owns the delay
  assign chosenDelay = state.calEnable ? state.result : state.manualDelay;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_state = state;
    events = 2'h0;
    next_state.readData = 8'h00;

    // Calibration sequence
    case (state.phase)
      CAL_IDLE: begin
      end
      CAL_SEEK: begin
        if (meterTooLong) begin
          next_state.phase = CAL_FAILED;
          events[IRQ_FAIL] = 1'b1;
        end else if (edgePulse && meterArmed) begin
          next_state.phase = CAL_WINDOW;
          next_state.windowCount = 9'h000;
          next_state.highCount = 9'h000;
        end
      end
      CAL_WINDOW: begin
        if (meterTooLong) begin
          next_state.phase = CAL_FAILED;
          events[IRQ_FAIL] = 1'b1;
        end else if (state.windowCount == windowLen - 9'h001) begin
          next_state.acc = accNext;
          next_state.avgCount = state.avgCount + 9'h001;
          if (state.avgCount + 9'h001 == avgTarget) begin
            // Saturate: a SYSREF high for the whole 256-cycle window overflows 16 bits
            next_state.result = (scaled[24:16] != 9'h000) ? 17'h0ffff : {1'b0, scaled[15:0]};
            next_state.complete = 1'b1;
            next_state.phase = CAL_DONE;
            events[IRQ_DONE] = 1'b1;
          end else begin
            next_state.phase = CAL_SEEK;
          end
        end else begin
          next_state.highCount = highNext;
          next_state.windowCount = state.windowCount + 9'h001;
        end
      end
      CAL_DONE: begin
      end
      CAL_FAILED: begin
      end
      default: begin
        next_state.phase = CAL_IDLE;
      end
    endcase

    if (startPulse) begin
      next_state.phase = CAL_SEEK;
      next_state.acc = 17'h00000;
      next_state.avgCount = 9'h000;
      next_state.complete = 1'b0;
    end

    // Register writes
    if (writeHit) begin
      case (regIndex)
        IDX_ENABLE: begin
          next_state.calEnable = busReq.writeData[0];
          if (!busReq.writeData[0]) begin
            next_state.phase = CAL_IDLE;
            next_state.complete = 1'b0;
          end
        end
        IDX_CONFIG: next_state.calConfig = busReq.writeData[3:0];
        IDX_MANUAL0: next_state.manualDelay[7:0] = busReq.writeData;
        IDX_MANUAL1: next_state.manualDelay[15:8] = busReq.writeData;
        IDX_MANUAL2: next_state.manualDelay[16] = busReq.writeData[0];
        IDX_IRQ_CLEAR: next_state.irqStatus = state.irqStatus & ~busReq.writeData[1:0];
        IDX_IRQ_ENABLE: next_state.irqEnable = busReq.writeData[1:0];
        default: begin
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    next_state.irqStatus = next_state.irqStatus | events;

    // Register reads, answered in the next cycle only
    if (busReq.readStrobe && aligned) begin
      case (regIndex)
        IDX_ENABLE: next_state.readData = {7'h00, state.calEnable};
        IDX_CONFIG: next_state.readData = {4'h0, state.calConfig};
        IDX_STATUS0: next_state.readData = statusWord[7:0];
        IDX_STATUS1: next_state.readData = statusWord[15:8];
        IDX_STATUS2: next_state.readData = statusWord[23:16];
        IDX_MANUAL0: next_state.readData = manualWord[7:0];
        IDX_MANUAL1: next_state.readData = manualWord[15:8];
        IDX_MANUAL2: next_state.readData = manualWord[23:16];
        IDX_IRQ_STATUS: next_state.readData = {6'h00, state.irqStatus};
        IDX_IRQ_ENABLE: next_state.readData = {6'h00, state.irqEnable};
        default: next_state.readData = 8'h00;
      endcase
    end

    // Delay outputs follow the chosen source one cycle later
    next_state.applied.clockInvert = chosenDelay[INVERT_BIT];
    next_state.applied.coarseDelay = chosenDelay[15:8];
    next_state.applied.fineDelay = chosenDelay[7:0];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign readData = state.readData;
  assign apertureDelay = state.applied;
  assign calibrating = (state.phase == CAL_SEEK) | (state.phase == CAL_WINDOW);
  assign irq = |(state.irqStatus & state.irqEnable);

endmodule // sysref_delay_calibration

// ### hdl/sysref_calib_pkg.sv
// Shared constants and carrier types of the aperture delay calibration block.
// Assumes a byte-wide register port in which each byte register takes one aligned word.
package sysref_calib_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_ENABLE = 10'h2b0;
  localparam logic [9:0] IDX_CONFIG = 10'h2b1;
  localparam logic [9:0] IDX_STATUS0 = 10'h2b2;
  localparam logic [9:0] IDX_STATUS1 = 10'h2b3;
  localparam logic [9:0] IDX_STATUS2 = 10'h2b4;
  localparam logic [9:0] IDX_MANUAL0 = 10'h2b5;
  localparam logic [9:0] IDX_MANUAL1 = 10'h2b6;
  localparam logic [9:0] IDX_MANUAL2 = 10'h2b7;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h2b9;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h2ba;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h2bb;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam logic [7:0] CONFIG_RESET = 8'h05;
  localparam int AVG_LSB = 2;
  localparam int WINDOW_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam int INVERT_BIT = 16;
  localparam logic [23:0] MANUAL_RESET = 24'h000000;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;

  // ==========================================================================
  // Counts per code: averages, window cycles, longest SYSREF period
  // ==========================================================================
  localparam logic [8:0] AVG_COUNT0 = 9'h004;
  localparam logic [8:0] AVG_COUNT1 = 9'h010;
  localparam logic [8:0] AVG_COUNT2 = 9'h040;
  localparam logic [8:0] AVG_COUNT3 = 9'h100;
  localparam logic [8:0] WINDOW_LEN0 = 9'h004;
  localparam logic [8:0] WINDOW_LEN1 = 9'h010;
  localparam logic [8:0] WINDOW_LEN2 = 9'h040;
  localparam logic [8:0] WINDOW_LEN3 = 9'h100;
  localparam logic [15:0] MAX_PERIOD0 = 16'd85;
  localparam logic [15:0] MAX_PERIOD1 = 16'd1100;
  localparam logic [15:0] MAX_PERIOD2 = 16'd5200;
  localparam logic [15:0] MAX_PERIOD3 = 16'd21580;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef enum logic [2:0] {CAL_IDLE, CAL_SEEK, CAL_WINDOW, CAL_DONE, CAL_FAILED} calPhase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] writeData;
    logic writeStrobe;
    logic readStrobe;
  } regBusReq_t;

  typedef struct packed {
    logic clockInvert;
    logic [7:0] coarseDelay;
    logic [7:0] fineDelay;
  } apertureDelay_t;

  typedef struct packed {
    logic prevLevel;
    logic armed;
    logic [15:0] count;
    logic tooLong;
  } meterState_t;

  typedef struct packed {
    logic calEnable;
    logic [3:0] calConfig;
    logic [16:0] manualDelay;
    logic [1:0] irqStatus;
    logic [1:0] irqEnable;
    logic [7:0] readData;
    calPhase_t phase;
    logic [8:0] avgCount;
    logic [8:0] windowCount;
    logic [8:0] highCount;
    logic [16:0] acc;
    logic [16:0] result;
    logic complete;
    apertureDelay_t applied;
  } calState_t;

endpackage

// ### hdl/sysref_period_meter.sv
// SYSREF edge detector and period watchdog.
// Assumes sysref is already synchronous to clock.
`timescale 1ns/1ps

module sysref_period_meter (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sysref,
  input wire logic clear,
  input wire logic [15:0] limit,
  output logic risingEdge,
  output logic armed,
  output logic tooLong
);
  import sysref_calib_pkg::*;

  meterState_t state;
  meterState_t next_state;

  assign risingEdge = sysref & ~state.prevLevel;
  assign armed = state.armed;
  assign tooLong = state.tooLong;

  always_comb begin
    next_state = state;
    next_state.prevLevel = sysref;
    if (clear) begin
      next_state.armed = 1'b0;
      next_state.count = 16'h0000;
      next_state.tooLong = 1'b0;
    end else if (risingEdge) begin
      next_state.armed = 1'b1;
      next_state.count = 16'h0000;
    end else begin
      // Saturate so a stopped SYSREF stays flagged
      if (state.count != 16'hffff) begin
        next_state.count = state.count + 16'h0001;
      end
      if (state.count > limit) begin
        next_state.tooLong = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule // sysref_period_meter

// ### dv/sysref_source.sv
// Periodic SYSREF source standing at the far side of the calibration block.
// Assumes the bench sets period and high time before raising run.
`timescale 1ns/1ps

module sysref_source (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic [15:0] period,
  input wire logic [15:0] highTime,
  output logic sysref
);
  logic [15:0] phase;
  // ==========================================================================
  // Pulse train, quiet outside a run
  // ==========================================================================
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= 16'h0000;
    end else if (!run || phase == period - 16'h0001) begin
      phase <= 16'h0000;
    end else begin
      phase <= phase + 16'h0001;
    end
  end
  assign sysref = run && (phase < highTime);
endmodule // sysref_source

// ### dv/sysref_calib_monitor.sv
// Port-level checker for the aperture delay calibration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps

module sysref_calib_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire sysref_calib_pkg::regBusReq_t busReq,
  input wire logic [7:0] readData,
  input wire logic sysref,
  input wire sysref_calib_pkg::apertureDelay_t apertureDelay,
  input wire logic calibrating,
  input wire logic irq
);
  import sysref_calib_pkg::*;
  logic enShadow;
  logic [16:0] manualShadow;
  logic wrOk;
  logic [9:0] idx;
  assign wrOk = busReq.writeStrobe && busReq.addr[1:0] == 2'h0;
  assign idx = busReq.addr[11:2];
  // ==========================================================================
  // Shadow of what software wrote, so outputs can be tied to their cause
  // ==========================================================================
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enShadow <= 1'b0;
      manualShadow <= 17'h00000;
    end else if (wrOk) begin
      if (idx == IDX_ENABLE) enShadow <= busReq.writeData[0];
      if (idx == IDX_MANUAL0) manualShadow[7:0] <= busReq.writeData;
      if (idx == IDX_MANUAL1) manualShadow[15:8] <= busReq.writeData;
      if (idx == IDX_MANUAL2) manualShadow[16] <= busReq.writeData[0];
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_read(logic [9:0] i);
    busReq.readStrobe && busReq.addr == {i, 2'b00};
  endsequence
  sequence s_enable_write(logic v);
    wrOk && idx == IDX_ENABLE && busReq.writeData[0] == v;
  endsequence
  a_config_reserved_zero: assert property (s_read(IDX_CONFIG) |=> readData[7:4] == 4'h0)
    else $error("config reserved bits not zero");
  a_status_reserved_zero: assert property (s_read(IDX_STATUS2) |=> readData[7:2] == 6'h00)
    else $error("status reserved bits not zero");
  a_done_needs_enable: assert property (s_read(IDX_STATUS2) and !enShadow |=> !readData[1])
    else $error("complete flag set while disabled");
  a_manual_top_zero: assert property (s_read(IDX_MANUAL2) |=> readData[7:1] == 7'h00)
    else $error("manual reserved bits not zero");
  a_manual_low_readback: assert property (s_read(IDX_MANUAL0) |=> readData == manualShadow[7:0])
    else $error("manual low byte readback wrong");
  a_start_on_rise: assert property (s_enable_write(1'b1) and !enShadow |=> calibrating)
    else $error("enable rise did not start calibration");
  a_abort_stops_run: assert property (s_enable_write(1'b0) |=> !calibrating [*2])
    else $error("disable did not stop calibration");
  a_manual_drives_delay: assert property (!enShadow && !$past(enShadow) && manualShadow == $past(manualShadow)
      |-> apertureDelay == manualShadow)
    else $error("aperture delay does not follow manual value");
endmodule // sysref_calib_monitor

bind sysref_delay_calibration sysref_calib_monitor i_monitor (.clock(clock), .rstn(rstn), .busReq(busReq),
  .readData(readData), .sysref(sysref), .apertureDelay(apertureDelay), .calibrating(calibrating), .irq(irq));

// ### dv/tb_top.sv
// Self-checking bench for the aperture delay calibration block.
// Assumes the package, both design modules and the SYSREF source model are compiled first.
`timescale 1ns/1ps
`define CHK(what, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", what, e, g); end end

module tb_top;
  import sysref_calib_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  regBusReq_t busReq = '0;
  logic [7:0] readData;
  logic sysref;
  apertureDelay_t apertureDelay;
  logic calibrating;
  logic irq;
  logic srcRun = 1'b0;
  logic [15:0] srcPeriod = 16'h0028;
  logic [15:0] srcHigh = 16'h000a;
  int n_errors = 0;
  int cmp_count = 0;
  int ncyc;
  always #2.5 clock = ~clock;
  sysref_delay_calibration i_dut (.clock(clock), .rstn(rstn), .busReq(busReq), .readData(readData),
    .sysref(sysref), .apertureDelay(apertureDelay), .calibrating(calibrating), .irq(irq));
  sysref_source i_src (.clock(clock), .rstn(rstn), .run(srcRun), .period(srcPeriod), .highTime(srcHigh),
    .sysref(sysref));
  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  function automatic logic [11:0] ba(logic [9:0] i);
    return {i, 2'b00};
  endfunction
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{addr: ba(i), writeData: d, writeStrobe: 1'b1, readStrobe: 1'b0};
    @(posedge clock);
    busReq <= '0;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    busReq <= '{addr: a, writeData: 8'h00, writeStrobe: 1'b0, readStrobe: 1'b1};
    @(posedge clock);
    busReq <= '0;
    #1;
    `CHK(what, e, readData)
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset_and_fields();
    chk_rd(ba(IDX_CONFIG), 8'h05, "config reset");
    for (int k = 0; k < 3; k++) chk_rd(ba(IDX_MANUAL0 + 10'(k)), 8'h00, "manual reset");
    chk_rd(ba(10'h2bc), 8'h00, "unmapped read");
    chk_rd(ba(IDX_CONFIG) + 12'h001, 8'h00, "misaligned read");
    wr(IDX_CONFIG, 8'hff);
    chk_rd(ba(IDX_CONFIG), 8'h0f, "config reserved");
    wr(IDX_MANUAL0, 8'hc3);
    wr(IDX_MANUAL1, 8'h5a);
    wr(IDX_MANUAL2, 8'hff);
    chk_rd(ba(IDX_MANUAL2), 8'h01, "manual top byte");
    chk_rd(ba(IDX_MANUAL0), 8'hc3, "manual fine");
    chk_rd(ba(IDX_MANUAL1), 8'h5a, "manual coarse");
    `CHK("manual delay out", 17'h15ac3, apertureDelay)
  endtask
  task automatic t_cal(input logic [1:0] avg, input logic [1:0] win, input logic [15:0] p,
      input logic [15:0] h, input logic [16:0] code);
    srcPeriod <= p;
    srcHigh <= h;
    srcRun <= 1'b1;
    wr(IDX_ENABLE, 8'h00);
    wr(IDX_CONFIG, {4'h0, avg, win});
    wr(IDX_ENABLE, 8'h01);
    #1;
    ncyc = 0;
    while (calibrating === 1'b1 && ncyc < 30000) begin
      @(posedge clock);
      #1;
      ncyc++;
    end
    srcRun <= 1'b0;
    if (code[16]) return;
    chk_rd(ba(IDX_STATUS0), code[7:0], "code low");
    chk_rd(ba(IDX_STATUS1), code[15:8], "code high");
    chk_rd(ba(IDX_STATUS2), 8'h02, "complete flag");
    chk_rd(ba(IDX_ENABLE), 8'h01, "enable readback");
    `CHK("applied result", code, apertureDelay)
  endtask
  task automatic t_averaging();
    int prev;
    prev = 0;
    for (int a = 0; a < 4; a++) begin
      t_cal(a[1:0], 2'h0, 16'd40, 16'd10, 17'h00400);
      `CHK("run long enough", 1'b1, ncyc >= (4 << (2 * a)) * 40)
      `CHK("run not too long", 1'b1, ncyc <= ((4 << (2 * a)) + 2) * 40)
      `CHK("longer with more averages", 1'b1, ncyc > prev)
      prev = ncyc;
    end
  endtask
  task automatic t_windows();
    logic [15:0] per [1:3] = '{16'd80, 16'd200, 16'd600};
    logic [15:0] hi [1:3] = '{16'd40, 16'd100, 16'd300};
    logic [16:0] cd [1:3] = '{17'h01000, 17'h04000, 17'h0ffff};
    for (int w = 1; w < 4; w++) t_cal(2'h0, w[1:0], per[w], hi[w], cd[w]);
  endtask
  task automatic t_irq_and_fail();
    chk_rd(ba(IDX_IRQ_STATUS), 8'h01, "done event");
    `CHK("masked irq", 1'b0, irq)
    wr(IDX_IRQ_ENABLE, 8'h03);
    #1;
    `CHK("irq raised", 1'b1, irq)
    chk_rd(ba(IDX_IRQ_ENABLE), 8'h03, "irq enable readback");
    wr(IDX_IRQ_CLEAR, 8'h01);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    wr(IDX_ENABLE, 8'h00);
    chk_rd(ba(IDX_STATUS2), 8'h00, "complete after disable");
    `CHK("manual back in use", 17'h15ac3, apertureDelay)
    t_cal(2'h0, 2'h0, 16'd200, 16'd10, 17'h10000);
    chk_rd(ba(IDX_IRQ_STATUS), 8'h02, "fail event");
    chk_rd(ba(IDX_STATUS2), 8'h00, "no complete on fail");
    `CHK("fail irq", 1'b1, irq)
    wr(IDX_IRQ_CLEAR, 8'h02);
    wr(IDX_ENABLE, 8'h00);
  endtask
  // ==========================================================================
  // Verdict, watchdog and main sequence
  // ==========================================================================
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    // About 50000 cycles, well over twice the expected run
    #250000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_reset_and_fields();
    t_averaging();
    t_windows();
    t_irq_and_fail();
    give_verdict();
  end
endmodule // tb_top
